// >>> core/pmc_power_ctrl.sv
// Power-mode controller: mode sequencing, clock gating, mask forcing.
// Assumes the core gives one-cycle wfi/halt pulses and level interrupts.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pmc_power_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire pmc_pkg::pmc_wb_req_type i_wb,
  input wire pmc_pkg::pmc_cpu_req_type i_cpu,
  input wire logic i_wdg_active,
  input wire logic i_wdg_halt_option,
  input wire logic i_stab_long,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output pmc_pkg::pmc_clk_type o_clk,
  output pmc_pkg::pmc_mode_type o_mode,
  output logic [1:0] o_cc_mask,
  output logic o_wake_irq,
  output logic o_rst_fetch,
  output logic o_wdg_rst,
  output logic o_wdg_hold
);
  import pmc_pkg::*;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT, ST_AHALT, ST_HALT, ST_STAB
  } pmc_state_type;

  pmc_state_type state_r; // Current state
  pmc_state_type state_nxt; // Next state
  logic slow_mode_enable_r; // Slow mode on
  logic [1:0] slow_divider_select_r; // Slow ratio selector
  logic timebase_int_enable_r; // Timebase interrupt enable
  logic [1:0] cc_stack_r; // Mask bits saved on wake service
  logic [12:0] stab_cnt_r; // Stabilisation counter
  logic stab_by_rst_r; // Stabilisation ends in reset fetch
  logic [12:0] stab_lim; // Selected stabilisation length
  logic stab_done; // Last stabilisation cycle
  logic mst_en; // Master clock enable
  logic div_slow_en; // Slow clock enable
  logic wb_req; // New bus request
  logic wdg_trip; // Halt request that ends in watchdog reset
  logic enter_low; // Entry to wait or either halt
  logic wake_irq_nxt; // Interrupt resume this cycle
  logic rst_fetch_nxt; // Reset resume this cycle
  pmc_mode_type mode_nxt; // Software-visible mode

  // Clock enable divider
  pmc_clk_div #(
    .MST_DIV(PMC_MST_DIV)
  ) u_div (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_sel(slow_divider_select_r),
    .o_mst_en(mst_en),
    .o_slow_en(div_slow_en)
  );

  assign wb_req = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign stab_lim = i_stab_long ? PMC_STAB_LONG : PMC_STAB_SHORT;
  assign stab_done = mst_en && (stab_cnt_r == stab_lim - 13'h1);
  // Halt with watchdog running and option set resets, unless timebase on
  assign wdg_trip = i_cpu.halt && i_wdg_active && i_wdg_halt_option
                    && !timebase_int_enable_r;

  // Next state and resume pulses
  always_comb begin
    state_nxt = state_r;
    wake_irq_nxt = 1'b0;
    rst_fetch_nxt = 1'b0;
    enter_low = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (i_cpu.wake_rst) begin
          rst_fetch_nxt = 1'b1;
        end else if (i_cpu.wait_for_interrupt_instr) begin
          state_nxt = ST_WAIT;
          enter_low = 1'b1;
        end else if (i_cpu.halt && !wdg_trip) begin
          // Timebase enable picks the halt flavour
          state_nxt = timebase_int_enable_r ? ST_AHALT : ST_HALT;
          enter_low = 1'b1;
        end
      end
      ST_WAIT: begin
        // Any interrupt or reset ends wait
        if (i_cpu.wake_rst) begin
          state_nxt = ST_RUN;
          rst_fetch_nxt = 1'b1;
        end else if (i_cpu.irq || i_cpu.tb_irq) begin
          state_nxt = ST_RUN;
          wake_irq_nxt = 1'b1;
        end
      end
      ST_AHALT: begin
        // Reset needs the oscillator delay, interrupts do not
        if (i_cpu.wake_rst) begin
          state_nxt = ST_STAB;
        end else if (i_cpu.irq || i_cpu.tb_irq) begin
          state_nxt = ST_RUN;
          wake_irq_nxt = 1'b1;
        end
      end
      ST_HALT: begin
        // The timebase source is not heard here; only interrupt and reset wake
        if (i_cpu.wake_rst || i_cpu.irq) begin
          state_nxt = ST_STAB;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          state_nxt = ST_RUN;
          wake_irq_nxt = !stab_by_rst_r;
          rst_fetch_nxt = stab_by_rst_r;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // State register, reset lands in RUN
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stabilisation counter and its exit kind
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stab_cnt_r <= 13'h0;
      stab_by_rst_r <= 1'b0;
    end else if (state_r != ST_STAB) begin
      stab_cnt_r <= 13'h0;
      stab_by_rst_r <= i_cpu.wake_rst;
    end else if (mst_en) begin
      stab_cnt_r <= stab_cnt_r + 13'h1;
    end
  end

  // Resume and watchdog pulses
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wake_irq <= 1'b0;
      o_rst_fetch <= 1'b0;
      o_wdg_rst <= 1'b0;
      o_wdg_hold <= 1'b0;
    end else begin
      o_wake_irq <= wake_irq_nxt;
      o_rst_fetch <= rst_fetch_nxt;
      o_wdg_rst <= (state_r == ST_RUN) && !i_cpu.wake_rst && !i_cpu.wait_for_interrupt_instr
                   && wdg_trip;
      // Watchdog reset held off while in active-halt
      o_wdg_hold <= (state_nxt == ST_AHALT);
    end
  end

  // Mask bits: forced on entry, pushed and loaded on interrupt wake, popped later
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cc_mask <= PMC_MASK_RST;
      cc_stack_r <= PMC_MASK_RST;
    end else if (enter_low) begin
      o_cc_mask <= PMC_MASK_WAKE;
    end else if (wake_irq_nxt) begin
      cc_stack_r <= o_cc_mask;
      o_cc_mask <= i_cpu.irq_level;
    end else if (i_cpu.cc_pop) begin
      o_cc_mask <= cc_stack_r;
    end else if (i_cpu.cc_wr) begin
      o_cc_mask <= i_cpu.cc_wdata;
    end
  end

  // Clock enables per state
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_clk <= '0;
    end else begin
      o_clk.osc_on <= (state_r != ST_HALT);
      o_clk.tb_en <= mst_en && (state_r != ST_HALT) && (state_r != ST_STAB);
      o_clk.cpu_en <= (state_r == ST_RUN)
                      && (slow_mode_enable_r ? div_slow_en : mst_en);
      o_clk.per_en <= ((state_r == ST_RUN) || (state_r == ST_WAIT))
                      && (slow_mode_enable_r ? div_slow_en : mst_en);
    end
  end

  // Software-visible mode
  always_comb begin
    case (state_r)
      ST_RUN: mode_nxt = slow_mode_enable_r ? PMC_M_SLOW : PMC_M_RUN;
      ST_WAIT: mode_nxt = slow_mode_enable_r ? PMC_M_SLOW_WAIT : PMC_M_WAIT;
      ST_AHALT: mode_nxt = PMC_M_ACT_HALT;
      ST_HALT: mode_nxt = PMC_M_HALT;
      default: mode_nxt = PMC_M_HALT;
    endcase
  end

  // Mode register
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mode <= PMC_M_RUN;
    end else begin
      o_mode <= mode_nxt;
    end
  end

  // Control register writes through byte lane 0
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slow_mode_enable_r <= 1'b0;
      slow_divider_select_r <= PMC_SEL_RST;
      timebase_int_enable_r <= 1'b0;
    end else if (wb_req && i_wb.we && i_wb.sel[0] && (i_wb.adr == PMC_CTRL_OFS)) begin
      slow_mode_enable_r <= i_wb.dat[PMC_CTRL_SLOW_BIT];
      slow_divider_select_r <= i_wb.dat[PMC_CTRL_SEL_LSB +: 2];
      timebase_int_enable_r <= i_wb.dat[PMC_CTRL_TBIE_BIT];
    end
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0;
      if (wb_req && !i_wb.we) begin
        if (i_wb.adr == PMC_CTRL_OFS) begin
          o_wb_dat[PMC_CTRL_SLOW_BIT] <= slow_mode_enable_r;
          o_wb_dat[PMC_CTRL_SEL_LSB +: 2] <= slow_divider_select_r;
          o_wb_dat[PMC_CTRL_TBIE_BIT] <= timebase_int_enable_r;
        end else if (i_wb.adr == PMC_STAT_OFS) begin
          o_wb_dat[PMC_STAT_MODE_LSB +: 3] <= mode_nxt;
          o_wb_dat[PMC_STAT_MASK_LSB +: 2] <= o_cc_mask;
          o_wb_dat[PMC_STAT_BUSY_BIT] <= (state_r == ST_STAB);
        end
      end
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_halt_tb;
    state_r == ST_RUN && i_cpu.halt && !i_cpu.wait_for_interrupt_instr && !i_cpu.wake_rst;
  endsequence

  sequence s_stab_exit;
    state_r == ST_STAB ##1 state_r == ST_RUN;
  endsequence

  property p_run_clk;
    state_r == ST_RUN && !slow_mode_enable_r && mst_en |=> o_clk.cpu_en;
  endproperty
  a_run_clk: assert property (p_run_clk) else $error("cpu clock missing in run");

  property p_slow_gap;
    state_r == ST_RUN && slow_mode_enable_r && !div_slow_en |=> !o_clk.cpu_en;
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("cpu clock too fast in slow");

  property p_wait_entry;
    state_r == ST_RUN && i_cpu.wait_for_interrupt_instr && !i_cpu.wake_rst
      |=> state_r == ST_WAIT && o_cc_mask == PMC_MASK_WAKE ##1 !o_clk.cpu_en;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");

  property p_slow_wait;
    state_r == ST_WAIT && slow_mode_enable_r |=> o_mode == PMC_M_SLOW_WAIT;
  endproperty
  a_slow_wait: assert property (p_slow_wait) else $error("slow-wait not shown");

  property p_halt_pick;
    s_halt_tb and timebase_int_enable_r |=> state_r == ST_AHALT && o_wdg_hold && !o_wdg_rst;
  endproperty
  a_halt_pick: assert property (p_halt_pick) else $error("active-halt not entered");

  property p_ahalt_fast;
    state_r == ST_AHALT && (i_cpu.irq || i_cpu.tb_irq) && !i_cpu.wake_rst
      |=> state_r == ST_RUN && o_wake_irq;
  endproperty
  a_ahalt_fast: assert property (p_ahalt_fast) else $error("active-halt wake delayed");

  property p_halt_no_tb;
    state_r == ST_HALT && i_cpu.tb_irq && !i_cpu.irq && !i_cpu.wake_rst |=> state_r == ST_HALT;
  endproperty
  a_halt_no_tb: assert property (p_halt_no_tb) else $error("timebase woke halt");

  property p_stab_len;
    s_stab_exit |-> $past(stab_cnt_r) == stab_lim - 13'h1 && (o_wake_irq || o_rst_fetch);
  endproperty
  a_stab_len: assert property (p_stab_len) else $error("stabilisation length wrong");

  property p_halt_osc;
    state_r == ST_HALT |=> !o_clk.osc_on && !o_clk.tb_en && !o_clk.per_en;
  endproperty
  a_halt_osc: assert property (p_halt_osc) else $error("clocks run in halt");

  property p_wdg_trip;
    s_halt_tb and wdg_trip |=> o_wdg_rst && state_r == ST_RUN;
  endproperty
  a_wdg_trip: assert property (p_wdg_trip) else $error("watchdog halt reset missing");
endmodule // pmc_power_ctrl
`default_nettype wire

// >>> core/pmc_pkg.sv
// Constants, types and carriers shared by the power-mode controller files.
// Assumes one 10 MHz clock and an active-low asynchronous reset.
package pmc_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] PMC_CTRL_OFS = 4'h0;
  localparam logic [3:0] PMC_STAT_OFS = 4'h4;
  // Control register fields
  localparam int PMC_CTRL_SLOW_BIT = 0;
  localparam int PMC_CTRL_SEL_LSB = 1;
  localparam int PMC_CTRL_TBIE_BIT = 3;
  // Status register fields
  localparam int PMC_STAT_MODE_LSB = 0;
  localparam int PMC_STAT_MASK_LSB = 4;
  localparam int PMC_STAT_BUSY_BIT = 6;
  // Reset and forced values of the mask bits, and reset value of the divider selector
  localparam logic [1:0] PMC_MASK_RST = 2'h3;
  localparam logic [1:0] PMC_MASK_WAKE = 2'h2;
  localparam logic [1:0] PMC_SEL_RST = 2'h0;
  // Master clock divide ratio from the oscillator
  localparam int PMC_MST_DIV = 2;
  // Stabilisation delays in master clock cycles
  localparam logic [12:0] PMC_STAB_SHORT = 13'h0100;
  localparam logic [12:0] PMC_STAB_LONG = 13'h1000;

  // Documented power mode as seen by software
  typedef enum logic [2:0] {
    PMC_M_RUN, PMC_M_SLOW, PMC_M_WAIT, PMC_M_SLOW_WAIT, PMC_M_ACT_HALT, PMC_M_HALT
  } pmc_mode_type;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmc_wb_req_type;

  // Requests and events from the processor core
  typedef struct packed {
    logic wait_for_interrupt_instr;
    logic halt;
    logic irq;
    logic tb_irq;
    logic wake_rst;
    logic cc_wr;
    logic [1:0] cc_wdata;
    logic cc_pop;
    logic [1:0] irq_level;
  } pmc_cpu_req_type;

  // Clock enables handed to the chip
  typedef struct packed {
    logic cpu_en;
    logic per_en;
    logic tb_en;
    logic osc_on;
  } pmc_clk_type;
endpackage

// >>> core/pmc_clk_div.sv
// Master clock and slow clock enable divider.
// Assumes the oscillator clock and a reset of the same domain.
`timescale 1ns/1ns
`default_nettype none
module pmc_clk_div #(
  parameter int MST_DIV = pmc_pkg::PMC_MST_DIV
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_sel,
  output logic o_mst_en,
  output logic o_slow_en
);
  import pmc_pkg::*;

  logic [3:0] mst_cnt_r; // Oscillator cycles within a master cycle
  logic [3:0] slow_cnt_r; // Master pulses within a slow cycle
  logic [3:0] slow_lim; // Last master pulse of a slow cycle
  logic mst_hit;

  assign mst_hit = (mst_cnt_r == 4'(MST_DIV - 1));
  // Ratio 2, 4, 8 or 16 from the two-bit selector
  assign slow_lim = 4'((5'h2 << i_sel) - 5'h1);

  // Master cycle counter
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mst_cnt_r <= 4'h0;
      o_mst_en <= 1'b0;
    end else begin
      mst_cnt_r <= mst_hit ? 4'h0 : mst_cnt_r + 4'h1;
      o_mst_en <= mst_hit;
    end
  end

  // Slow cycle counter, stepped by master pulses
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slow_cnt_r <= 4'h0;
      o_slow_en <= 1'b0;
    end else begin
      o_slow_en <= 1'b0;
      if (mst_hit) begin
        // Selector change applies to the cycle in progress; a count at or past a lower limit wraps at once
        if (slow_cnt_r >= slow_lim) begin
          slow_cnt_r <= 4'h0;
          o_slow_en <= 1'b1;
        end else begin
          slow_cnt_r <= slow_cnt_r + 4'h1;
        end
      end
    end
  end
endmodule // pmc_clk_div
`default_nettype wire

// >>> tb/pmc_core_model.sv
// Behavioural processor core that faces the power-mode controller.
// Assumes the controller's clock; requests change right after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module pmc_core_model (
  input wire logic i_mclk,
  input wire logic i_wake_irq,
  input wire logic i_rst_fetch,
  output pmc_pkg::pmc_cpu_req_type o_req
);
  import pmc_pkg::*;
  int ret_cnt = 0; // Cycles left in the interrupt routine
  initial o_req = '0;
  // One-cycle wfi or halt instruction pulse
  task automatic instr(input logic is_halt);
    @(posedge i_mclk);
    o_req.wait_for_interrupt_instr <= !is_halt;
    o_req.halt <= is_halt;
    @(posedge i_mclk);
    o_req.wait_for_interrupt_instr <= 1'b0;
    o_req.halt <= 1'b0;
  endtask
  // One-cycle software write of the mask bits
  task automatic cc_write(input logic [1:0] v);
    @(posedge i_mclk);
    o_req.cc_wr <= 1'b1;
    o_req.cc_wdata <= v;
    @(posedge i_mclk);
    o_req.cc_wr <= 1'b0;
  endtask
  // Wake sources are levels that stay until serviced
  task automatic raise(input logic irq, input logic tb, input logic rst, input logic [1:0] lvl);
    @(posedge i_mclk);
    o_req.irq <= irq;
    o_req.tb_irq <= tb;
    o_req.wake_rst <= rst;
    o_req.irq_level <= lvl;
  endtask
  // Servicing clears the sources; the routine returns by popping the mask
  always @(posedge i_mclk) begin
    o_req.cc_pop <= (ret_cnt == 1);
    if (ret_cnt != 0) ret_cnt <= ret_cnt - 1;
    if (i_wake_irq) begin
      o_req.irq <= 1'b0;
      o_req.tb_irq <= 1'b0;
      ret_cnt <= 8;
    end
    if (i_rst_fetch) o_req.wake_rst <= 1'b0;
  end
endmodule // pmc_core_model
`default_nettype wire

// >>> tb/power_mode_controller_tb_top.sv
// Bench for the power-mode controller: bus tasks, mode scenarios, verdict.
// Assumes the package, the controller and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller_tb_top;
  import pmc_pkg::*;
  logic clk = 1'b0; // Oscillator clock
  logic rst_b = 1'b0; // Reset, low active
  logic wdg_act = 1'b0; // Watchdog running
  logic wdg_opt = 1'b0; // Halt-with-watchdog option
  logic stab_long = 1'b0; // Long stabilisation select
  pmc_wb_req_type wb = '0; // Bus request
  pmc_cpu_req_type cpu; // Core requests
  pmc_clk_type clks; // Clock enables
  pmc_mode_type mode; // Reported mode
  logic ack, wake, rfetch, wrst, whold; // Pulses and levels from the controller
  logic [31:0] rdat; // Bus read data
  logic [1:0] mask; // Interrupt mask bits
  logic [31:0] q; // Last read value
  logic [3:0] bsel = 4'h1; // Byte lanes of the next access
  int fail_count = 0; // Mismatches
  int n_checks = 0; // Comparisons
  int n; // Cycles of the last wait
  int c[4]; // Counts of cpu, peripheral, timebase enables and watchdog resets
  pmc_power_ctrl DUT (.i_mclk(clk), .i_rst_b(rst_b), .i_wb(wb), .i_cpu(cpu),
    .i_wdg_active(wdg_act), .i_wdg_halt_option(wdg_opt), .i_stab_long(stab_long),
    .o_wb_ack(ack), .o_wb_dat(rdat), .o_clk(clks), .o_mode(mode), .o_cc_mask(mask),
    .o_wake_irq(wake), .o_rst_fetch(rfetch), .o_wdg_rst(wrst), .o_wdg_hold(whold));
  pmc_core_model core (.i_mclk(clk), .i_wake_irq(wake), .i_rst_fetch(rfetch), .o_req(cpu));
  // 100 ns clock
  initial forever #50 clk = ~clk;
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Exact value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Cycle count inside a window
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("mismatch at %0t got %h range %h %h", $time, got, lo, hi);
    end
  endtask
  // Classic single Wishbone cycle; held until ack is sampled high
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] d,
                     output logic [31:0] rd);
    int k = 0;
    @(posedge clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: bsel, dat: d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = rdat;
    wb <= '0;
    if (ack !== 1'b1) begin
      chk(32'(ack), 32'h1);
      close_out();
    end
  endtask
  // Control write, then let the dividers settle
  task automatic wr_ctrl(input logic [31:0] d);
    bus(1'b1, PMC_CTRL_OFS, d, q);
    repeat (40) @(posedge clk);
  endtask
  // Bounded wait for wake (0), reset fetch (1) or watchdog reset (2)
  task automatic wait_ev(input int which, input int lim);
    logic hit;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      hit = (which == 0) ? wake : (which == 1) ? rfetch : wrst;
    end while (hit !== 1'b1 && n < lim);
    if (hit !== 1'b1) begin
      chk(32'(hit), 32'h1);
      close_out();
    end
  endtask
  // Pulse counts over a window
  task automatic cnt(input int len);
    c = '{default: 0};
    repeat (len) begin
      @(posedge clk);
      c[0] += int'(clks.cpu_en === 1'b1);
      c[1] += int'(clks.per_en === 1'b1);
      c[2] += int'(clks.tb_en === 1'b1);
      c[3] += int'(wrst === 1'b1);
    end
  endtask
  // Reset values, then master rate in RUN
  task automatic t_reset;
    repeat (12) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_RUN));
    chk(32'(mask), 32'(PMC_MASK_RST));
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    cnt(64);
    chk(32'(c[0]), 32'(64 / PMC_MST_DIV));
    chk(32'(c[1]), 32'(64 / PMC_MST_DIV));
  endtask
  // Every divider selection, status read and an unmapped read
  task automatic t_slow;
    for (int s = 0; s < 4; s++) begin
      wr_ctrl((32'h1 << PMC_CTRL_SLOW_BIT) | (32'(s) << PMC_CTRL_SEL_LSB));
      cnt(128);
      chk(32'(c[0]), 32'(128 / (4 << s)));
      chk(32'(c[1]), 32'(128 / (4 << s)));
      chk(32'(mode), 32'(PMC_M_SLOW));
    end
    bus(1'b0, PMC_STAT_OFS, 32'h0, q);
    chk(q, 32'(PMC_M_SLOW) | (32'(PMC_MASK_RST) << PMC_STAT_MASK_LSB));
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    // Control read-back, then a write without lane 0 and an unmapped write
    bus(1'b0, PMC_CTRL_OFS, 32'h0, q);
    chk(q, (32'h1 << PMC_CTRL_SLOW_BIT) | (32'h3 << PMC_CTRL_SEL_LSB));
    bsel <= 4'he;
    bus(1'b1, PMC_CTRL_OFS, 32'h0, q);
    bsel <= 4'h1;
    bus(1'b1, 4'h8, 32'h0, q);
    bus(1'b0, PMC_CTRL_OFS, 32'h0, q);
    chk(q, (32'h1 << PMC_CTRL_SLOW_BIT) | (32'h3 << PMC_CTRL_SEL_LSB));
  endtask
  // Wait entered from slow, interrupt wake, mask push and pop
  task automatic t_slow_wait;
    wr_ctrl((32'h1 << PMC_CTRL_SLOW_BIT) | (32'h1 << PMC_CTRL_SEL_LSB));
    // Software lowers the mask first so the forced value is visible
    core.cc_write(2'h1);
    @(posedge clk);
    chk(32'(mask), 32'h1);
    core.instr(1'b0);
    repeat (3) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_SLOW_WAIT));
    chk(32'(mask), 32'(PMC_MASK_WAKE));
    cnt(128);
    chk(32'(c[0]), 32'h0);
    chk(32'(c[1]), 32'd16);
    core.raise(1'b1, 1'b0, 1'b0, 2'h1);
    wait_ev(0, 6);
    chk(32'(mask), 32'h1);
    repeat (14) @(posedge clk);
    chk(32'(mask), 32'(PMC_MASK_WAKE));
  endtask
  // Plain wait left by a reset request
  task automatic t_wait_rst;
    wr_ctrl(32'h0);
    core.instr(1'b0);
    repeat (3) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_WAIT));
    cnt(64);
    chk(32'(c[0]), 32'h0);
    chk(32'(c[1]), 32'(64 / PMC_MST_DIV));
    core.raise(1'b0, 1'b0, 1'b1, 2'h0);
    wait_ev(1, 6);
    repeat (3) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_RUN));
  endtask
  // Active-halt: gating, watchdog held off, quick and reset exits, pending wake
  task automatic t_act_halt;
    wdg_act <= 1'b1;
    wdg_opt <= 1'b1;
    wr_ctrl(32'h1 << PMC_CTRL_TBIE_BIT);
    core.instr(1'b1);
    repeat (3) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_ACT_HALT));
    chk(32'(whold), 32'h1);
    chk(32'(mask), 32'(PMC_MASK_WAKE));
    chk(32'(clks.osc_on), 32'h1);
    cnt(64);
    chk(32'(c[0] + c[1]), 32'h0);
    chk_rng(c[2], 1, 64);
    chk(32'(c[3]), 32'h0);
    core.raise(1'b0, 1'b1, 1'b0, 2'h0);
    wait_ev(0, 4);
    repeat (12) @(posedge clk);
    chk(32'(whold), 32'h0);
    core.instr(1'b1);
    core.raise(1'b0, 1'b0, 1'b1, 2'h0);
    wait_ev(1, 600);
    chk_rng(n, 500, 540);
    // Let the core drop its reset request before the next stimulus
    repeat (2) @(posedge clk);
    core.raise(1'b1, 1'b0, 1'b0, 2'h3);
    core.instr(1'b1);
    wait_ev(0, 4);
    repeat (12) @(posedge clk);
  endtask
  // Full halt: clocks stopped, timebase ignored, both delays
  task automatic t_halt;
    wdg_opt <= 1'b0;
    wr_ctrl(32'h0);
    core.instr(1'b1);
    repeat (3) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_HALT));
    chk(32'(clks.osc_on), 32'h0);
    chk(32'(mask), 32'(PMC_MASK_WAKE));
    cnt(32);
    chk(32'(c[0] + c[1] + c[2]), 32'h0);
    core.raise(1'b0, 1'b1, 1'b0, 2'h0);
    repeat (40) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_HALT));
    core.raise(1'b1, 1'b1, 1'b0, 2'h2);
    wait_ev(0, 600);
    chk_rng(n, 500, 540);
    repeat (12) @(posedge clk);
    stab_long <= 1'b1;
    core.instr(1'b1);
    core.raise(1'b0, 1'b0, 1'b1, 2'h0);
    wait_ev(1, 8400);
    chk_rng(n, 8180, 8230);
    stab_long <= 1'b0;
  endtask
  // Halt with the option set and watchdog running gives a reset instead
  task automatic t_wdg;
    wdg_opt <= 1'b1;
    repeat (4) @(posedge clk);
    core.instr(1'b1);
    wait_ev(2, 4);
    repeat (2) @(posedge clk);
    chk(32'(mode), 32'(PMC_M_RUN));
  endtask
  // Main sequence
  initial begin
    t_reset();
    t_slow();
    t_slow_wait();
    t_wait_rst();
    t_act_halt();
    t_halt();
    t_wdg();
    close_out();
  end
endmodule // power_mode_controller_tb_top
`default_nettype wire
